// >>> rtl/two_entry_buffer.v
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
  parameter WIDTH = 9,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire sys_clk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // two_entry_buffer

`default_nettype wire

// >>> rtl/uart_consts.vh
`ifndef UART_CONSTS_VH
`define UART_CONSTS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_MODE 8'h00
`define ADDR_BAUD_DIV 8'h04
`define ADDR_TX_DATA 8'h08
`define ADDR_RX_DATA 8'h0c
`define ADDR_STATUS 8'h10

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define MODE_STOP_SEL 0
`define MODE_PARITY_DATA_SELECT_LO 1
`define MODE_PARITY_DATA_SELECT_HI 2
`define MODE_HIGH_SPEED 3
`define MODE_RX_INV 4
`define MODE_WIDTH 5

// ----------------------------------------
// Parity and data select codes
// ----------------------------------------
`define PARITY_DATA_SELECT_8N 2'b00
`define PARITY_DATA_SELECT_8E 2'b01
`define PARITY_DATA_SELECT_8O 2'b10
`define PARITY_DATA_SELECT_9N 2'b11

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define STAT_RX_FULL 0
`define STAT_PAR_ERR 1
`define STAT_FRM_ERR 2
`define STAT_OVERRUN 3
`define STAT_TX_BUSY 4
`define STAT_TX_SPACE 5

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define MODE_RESET 5'h00
`define BAUD_DIV_RESET 16'h001a
`define TICKS_HIGH_SPEED 5'h04
`define TICKS_STANDARD 5'h10

`endif

// >>> rtl/uart_frame_format_config.v
// Summary of operation
// - With the polarity invert bit set the receive line idles low, otherwise high.
// - With the high-speed select set there are four baud ticks per bit.
// - With the high-speed select clear there are sixteen baud ticks per bit.
// - Parity select 11 is 9 data bits, 10 is 8 odd, 01 is 8 even, 00 is 8 no parity.
// - With the stop select set a transmitted frame has two stop bits, otherwise one; the receiver checks only the first stop bit.
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.vh"
module uart_frame_format_config (
  input wire sys_clk,
  input wire rstn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire serial_receive_line,
  output reg serial_transmit_line
);
  localparam ST_IDLE = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_DATA = 3'd2;
  localparam ST_PARITY = 3'd3;
  localparam ST_STOP = 3'd4;
  // ----------------------------------------
  // Registers and configuration
  // ----------------------------------------
  reg [`MODE_WIDTH-1:0] serial_port_mode_register;
  reg [15:0] baud_div;
  reg [8:0] rx_data;
  reg rx_full;
  reg par_err;
  reg frm_err;
  reg overrun;
  wire stop_bit_count_select = serial_port_mode_register[`MODE_STOP_SEL];
  wire [1:0] parity_data_select = serial_port_mode_register[`MODE_PARITY_DATA_SELECT_HI:`MODE_PARITY_DATA_SELECT_LO];
  wire high_speed_baud_select = serial_port_mode_register[`MODE_HIGH_SPEED];
  wire rx_idle_polarity_invert = serial_port_mode_register[`MODE_RX_INV];
  wire nine_bit = (parity_data_select == `PARITY_DATA_SELECT_9N);
  wire parity_on = (parity_data_select == `PARITY_DATA_SELECT_8E) |
                   (parity_data_select == `PARITY_DATA_SELECT_8O);
  wire parity_odd = (parity_data_select == `PARITY_DATA_SELECT_8O);
  wire [3:0] last_bit = nine_bit ? 4'd8 : 4'd7;
  wire [4:0] ticks_per_bit = high_speed_baud_select ?
    `TICKS_HIGH_SPEED : `TICKS_STANDARD;
  wire [4:0] half_bit = {1'b0, ticks_per_bit[4:1]};
  reg dp_valid;
  reg dp_write;
  reg [7:0] dp_addr;
  wire tx_in_ready;
  wire addr_take = hsel & htrans[1] & hready;
  wire tx_write_dp = dp_valid & dp_write & (dp_addr == `ADDR_TX_DATA);
  wire dp_done = ~tx_write_dp | tx_in_ready;
  wire rd_rx = addr_take & ~hwrite & (haddr == `ADDR_RX_DATA);
  wire stat_clr = dp_valid & dp_write & (dp_addr == `ADDR_STATUS);
  assign hreadyout = ~dp_valid | dp_done;
  assign hresp = 1'b0;
  wire tx_out_valid;
  wire tx_out_ready;
  wire [8:0] tx_out_data;
  two_entry_buffer #(.WIDTH(9), .DEPTH(2), .AW(1)) two_entry_buffer_inst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(tx_write_dp),
    .in_ready(tx_in_ready),
    .in_data(hwdata[8:0]),
    .out_valid(tx_out_valid),
    .out_ready(tx_out_ready),
    .out_data(tx_out_data)
  );
  // ----------------------------------------
  // Baud rate generator
  // ----------------------------------------
  reg [15:0] baud_cnt;
  wire baud_tick = (baud_cnt >= baud_div);
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      baud_cnt <= 16'h0000;
    end else if (baud_tick) begin
      baud_cnt <= 16'h0000;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
    end
  end
  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  reg [2:0] tx_state;
  reg [4:0] tx_tick;
  reg [3:0] tx_bit;
  reg [8:0] tx_shift;
  reg tx_par;
  wire tx_bit_end = baud_tick & (tx_tick == ticks_per_bit - 5'd1);
  assign tx_out_ready = (tx_state == ST_IDLE);
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_state <= ST_IDLE;
      tx_tick <= 5'd0;
      tx_bit <= 4'd0;
      tx_shift <= 9'h000;
      tx_par <= 1'b0;
      serial_transmit_line <= 1'b1;
    end else begin
      if (baud_tick) begin
        tx_tick <= tx_bit_end ? 5'd0 : tx_tick + 5'd1;
      end
      case (tx_state)
        ST_IDLE: begin
          serial_transmit_line <= 1'b1;
          tx_tick <= 5'd0;
          if (tx_out_valid) begin
            tx_shift <= tx_out_data;
            tx_par <= (^tx_out_data[7:0]) ^ parity_odd;
            tx_state <= ST_START;
            serial_transmit_line <= 1'b0;
          end
        end
        ST_START: begin
          if (tx_bit_end) begin
            tx_state <= ST_DATA;
            tx_bit <= 4'd0;
            serial_transmit_line <= tx_shift[0];
          end
        end
        ST_DATA: begin
          if (tx_bit_end) begin
            if (tx_bit == last_bit) begin
              tx_bit <= 4'd0;
              tx_state <= parity_on ? ST_PARITY : ST_STOP;
              serial_transmit_line <= parity_on ? tx_par : 1'b1;
            end else begin
              tx_bit <= tx_bit + 4'd1;
              tx_shift <= {1'b0, tx_shift[8:1]};
              serial_transmit_line <= tx_shift[1];
            end
          end
        end
        ST_PARITY: begin
          if (tx_bit_end) begin
            tx_state <= ST_STOP;
            serial_transmit_line <= 1'b1;
          end
        end
        ST_STOP: begin
          if (tx_bit_end) begin
            if (stop_bit_count_select & (tx_bit == 4'd0)) begin
              tx_bit <= 4'd1;
            end else begin
              tx_state <= ST_IDLE;
            end
          end
        end
        default: tx_state <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  reg rx_meta;
  reg rx_sync;
  reg [2:0] rx_state;
  reg [4:0] rx_tick;
  reg [3:0] rx_bit;
  reg [8:0] rx_shift;
  reg rx_par;
  wire rx_level = rx_sync ^ rx_idle_polarity_invert;
  wire rx_sample = baud_tick & (rx_tick == ticks_per_bit - 5'd1);
  wire rx_done = (rx_state == ST_STOP) & rx_sample;
  wire rx_par_bad = parity_on & (rx_par != ((^rx_shift[8:1]) ^ parity_odd));
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= serial_receive_line;
      rx_sync <= rx_meta;
    end
  end
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_state <= ST_IDLE;
      rx_tick <= 5'd0;
      rx_bit <= 4'd0;
      rx_shift <= 9'h000;
      rx_par <= 1'b0;
    end else begin
      if (baud_tick) begin
        rx_tick <= rx_sample ? 5'd0 : rx_tick + 5'd1;
      end
      case (rx_state)
        ST_IDLE: begin
          rx_tick <= 5'd0;
          if (!rx_level) begin
            rx_state <= ST_START;
          end
        end
        ST_START: begin
          if (baud_tick & (rx_tick == half_bit - 5'd1)) begin
            rx_tick <= 5'd0;
            rx_bit <= 4'd0;
            rx_state <= rx_level ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_sample) begin
            rx_shift <= {rx_level, rx_shift[8:1]};
            rx_bit <= rx_bit + 4'd1;
            if (rx_bit == last_bit) begin
              rx_state <= parity_on ? ST_PARITY : ST_STOP;
            end
          end
        end
        ST_PARITY: begin
          if (rx_sample) begin
            rx_par <= rx_level;
            rx_state <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (rx_sample) begin
            rx_state <= ST_IDLE;
          end
        end
        default: rx_state <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  wire [8:0] rx_word = nine_bit ? rx_shift : {1'b0, rx_shift[8:1]};
  wire [31:0] status_word = {26'h0, tx_in_ready, (tx_state != ST_IDLE),
                             overrun, frm_err, par_err, rx_full};
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h00000000;
      serial_port_mode_register <= `MODE_RESET;
      baud_div <= `BAUD_DIV_RESET;
      rx_data <= 9'h000;
      rx_full <= 1'b0;
      par_err <= 1'b0;
      frm_err <= 1'b0;
      overrun <= 1'b0;
    end else begin
      if (hreadyout) begin
        dp_valid <= addr_take;
        dp_write <= hwrite;
        dp_addr <= haddr;
      end
      if (addr_take & ~hwrite) begin
        case (haddr)
          `ADDR_MODE: hrdata <= {27'h0, serial_port_mode_register};
          `ADDR_BAUD_DIV: hrdata <= {16'h0000, baud_div};
          `ADDR_RX_DATA: hrdata <= {23'h0, rx_data};
          `ADDR_STATUS: hrdata <= status_word;
          default: hrdata <= 32'h00000000;
        endcase
      end
      if (dp_valid & dp_write & (dp_addr == `ADDR_MODE)) begin
        serial_port_mode_register <= hwdata[`MODE_WIDTH-1:0];
      end
      if (dp_valid & dp_write & (dp_addr == `ADDR_BAUD_DIV)) begin
        baud_div <= hwdata[15:0];
      end
      if (rx_done) begin
        rx_data <= rx_word;
        rx_full <= 1'b1;
      end else if (rd_rx) begin
        rx_full <= 1'b0;
      end
      if (rx_done & rx_par_bad) begin
        par_err <= 1'b1;
      end else if (stat_clr & hwdata[`STAT_PAR_ERR]) begin
        par_err <= 1'b0;
      end
      if (rx_done & ~rx_level) begin
        frm_err <= 1'b1;
      end else if (stat_clr & hwdata[`STAT_FRM_ERR]) begin
        frm_err <= 1'b0;
      end
      if (rx_done & rx_full & ~rd_rx) begin
        overrun <= 1'b1;
      end else if (stat_clr & hwdata[`STAT_OVERRUN]) begin
        overrun <= 1'b0;
      end
    end
  end
endmodule // uart_frame_format_config
`default_nettype wire

// >>> sim/serial_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
  input wire logic sys_clk,
  input wire logic tx_line,
  output logic rx_line
);
  int cyc = 0;
  initial rx_line = 1'b1;
  always @(posedge sys_clk) cyc <= cyc + 1;
  // ----------------------------------------
  // Frame bits, start first
  // ----------------------------------------
  function automatic logic [12:0] frame(input logic [8:0] d, input int nd, par, ns);
    logic [12:0] f;
    int n;
    f = '0;
    n = 1;
    for (int k = 0; k < nd; k++) begin
      f[n] = d[k];
      n++;
    end
    if (par != 0) begin
      f[n] = ^d[7:0] ^ (par == 2);
      n++;
    end
    for (int k = 0; k < ns; k++) begin
      f[n] = 1'b1;
      n++;
    end
    return f;
  endfunction
  task automatic set_idle(input logic inv);
    @(posedge sys_clk) rx_line <= ~inv;
  endtask
  task automatic send(input logic [8:0] d, input int nd, par, ns, input logic inv, input int bc);
    logic [12:0] f;
    f = frame(d, nd, par, ns);
    for (int k = 0; k < 1 + nd + (par != 0) + ns; k++) begin
      rx_line <= f[k] ^ inv;
      repeat (bc) @(posedge sys_clk);
    end
  endtask
  task automatic recv(input int n, bc, output logic [12:0] b, output int tf);
    b = '0;
    while (tx_line !== 1'b0) @(posedge sys_clk);
    tf = cyc;
    repeat (bc / 2) @(posedge sys_clk);
    for (int k = 0; k < n; k++) begin
      if (k > 0) repeat (bc) @(posedge sys_clk);
      b[k] = tx_line;
    end
  endtask
endmodule // serial_far_end
`default_nettype wire

// >>> sim/uart_frame_format_config_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.vh"
module uart_frame_format_config_asserts (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic serial_receive_line,
  input wire logic serial_transmit_line
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic rd_take = hsel && htrans[1] && hready && !hwrite;
  logic tx_dp;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) tx_dp <= 1'b0;
    else if (hready) tx_dp <= hsel && htrans[1] && hwrite && haddr == `ADDR_TX_DATA;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_read_no_wait: assert property (rd_take |=> hreadyout)
    else $error("read stalled");
  a_unmapped_zero: assert property (rd_take && haddr == 8'h14 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_stands: assert property (!rd_take |=> $stable(hrdata))
    else $error("hrdata changed");
  a_stall_tx_write: assert property (!hreadyout |-> tx_dp)
    else $error("stall outside tx write");
  a_tx_low_min: assert property ($fell(serial_transmit_line) |-> !serial_transmit_line[*3])
    else $error("tx low too short");
  a_tx_high_min: assert property ($rose(serial_transmit_line) |-> serial_transmit_line[*3])
    else $error("tx high too short");
  a_tx_low_bound: assert property ($fell(serial_transmit_line) |-> ##[1:1000] serial_transmit_line)
    else $error("tx stuck low");
  c_rx_read: cover property (rd_take && haddr == `ADDR_RX_DATA);
  c_stall: cover property (!hreadyout);
  c_tx_start: cover property ($fell(serial_transmit_line));
endmodule // uart_frame_format_config_asserts
bind uart_frame_format_config uart_frame_format_config_asserts uart_frame_format_config_asserts_inst (
  .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .serial_receive_line(serial_receive_line),
  .serial_transmit_line(serial_transmit_line));
`default_nettype wire

// >>> sim/uart_frame_format_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_consts.vh"
`define chk(x, y) begin \
  compares++; \
  if ((x) !== (y)) begin \
    errors++; \
    $display("Error at %0t: got %0h want %0h", $time, x, y); \
  end \
end
module uart_frame_format_config_bench;
  logic sys_clk = 0, rstn = 0, hsel = 0, hwrite = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 0, rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, tx, rx;
  wire hready = hreadyout;
  int errors = 0, compares = 0, cyc = 0, stalls = 0;
  uart_frame_format_config uart_frame_format_config_inst (.sys_clk(sys_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .serial_receive_line(rx), .serial_transmit_line(tx));
  serial_far_end serial_far_end_inst (.sys_clk(sys_clk), .tx_line(tx), .rx_line(rx));
  always #10 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task print_verdict();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      stalls++;
      @(posedge sys_clk);
    end
    r = hrdata;
  endtask
  function automatic logic [8:0] dat(input logic [4:0] m, input int i);
    return {m[0] ^ i[0], 8'h5a ^ {m, i[2:0]}};
  endfunction
  task automatic t_reset();
    bus(0, `ADDR_MODE, 0, rd);
    `chk(rd, 32'h0)
    bus(0, `ADDR_BAUD_DIV, 0, rd);
    `chk(rd, 32'h1a)
    bus(0, `ADDR_STATUS, 0, rd);
    `chk(rd, 32'h20)
    bus(0, 8'h14, 0, rd);
    `chk(rd, 32'h0)
    bus(1, `ADDR_BAUD_DIV, 0, rd);
    $display("test reset done");
  endtask
  task automatic t_mode(input logic [4:0] m);
    int nd, par, ns, bc, n, i, t0, t1;
    logic [12:0] b;
    logic [8:0] d;
    nd = (m[2:1] == 2'b11) ? 9 : 8;
    par = (m[2:1] == 2'b01) ? 1 : (m[2:1] == 2'b10) ? 2 : 0;
    ns = m[0] + 1;
    bc = m[3] ? 4 : 16;
    n = 1 + nd + (par != 0) + ns;
    bus(1, `ADDR_MODE, {27'h0, m}, rd);
    bus(0, `ADDR_MODE, 0, rd);
    `chk(rd, {27'h0, m})
    serial_far_end_inst.set_idle(m[4]);
    repeat (2 * bc) @(posedge sys_clk);
    stalls = 0;
    fork
      for (int k = 0; k < 4; k++) bus(1, `ADDR_TX_DATA, {23'h0, dat(m, k)}, rd);
      for (int k = 0; k < 4; k++) begin
        serial_far_end_inst.recv(n, bc, b, t1);
        `chk(b, serial_far_end_inst.frame(dat(m, k), nd, par, ns))
        if (k > 0) `chk((t1 - t0) inside {[n*bc-2:n*bc+2]}, 1'b1)
        t0 = t1;
      end
    join
    `chk(stalls > 0, 1'b1)
    d = dat(m, 5);
    serial_far_end_inst.send(d, nd, par, ns, m[4], bc);
    i = 0;
    do begin
      bus(0, `ADDR_STATUS, 0, rd);
      i++;
    end while (rd[0] !== 1'b1 && i < 50);
    `chk(rd[3:0], 4'h1)
    bus(0, `ADDR_RX_DATA, 0, rd);
    `chk(rd[8:0], nd == 9 ? d : {1'b0, d[7:0]})
    $display("test mode %h done", m);
  endtask
  task automatic t_errors();
    logic [31:0] r;
    bus(1, `ADDR_MODE, 32'h0000000a, r);
    repeat (8) @(posedge sys_clk);
    serial_far_end_inst.send(9'h0a5, 8, 2, 1, 1'b0, 4);
    serial_far_end_inst.send(9'h05a, 8, 1, 1, 1'b0, 4);
    repeat (8) @(posedge sys_clk);
    bus(0, `ADDR_STATUS, 0, r);
    `chk(r[3:0], 4'hb)
    bus(1, `ADDR_STATUS, 32'h0000000e, r);
    bus(0, `ADDR_STATUS, 0, r);
    `chk(r[3:0], 4'h1)
    bus(0, `ADDR_RX_DATA, 0, r);
    `chk(r[8:0], 9'h05a)
    bus(1, `ADDR_MODE, 32'h00000008, r);
    serial_far_end_inst.send(9'h0a5, 9, 0, 1, 1'b0, 4);
    repeat (8) @(posedge sys_clk);
    bus(0, `ADDR_STATUS, 0, r);
    `chk(r[3:0], 4'h5)
    bus(0, `ADDR_RX_DATA, 0, r);
    `chk(r[8:0], 9'h0a5)
    bus(1, `ADDR_STATUS, 32'h00000004, r);
    bus(0, `ADDR_STATUS, 0, r);
    `chk(r[3:0], 4'h0)
    $display("test errors done");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_errors();
    for (int k = 0; k < 32; k++) t_mode(5'(k));
    print_verdict();
  end
endmodule // uart_frame_format_config_bench
`default_nettype wire
